// [rtl/mrsf_framer.v]
/*
  Meter result serial framer: mode control from dial and buttons,
  session framing (header, measurement words, end sequence) and a
  UART transmitter or SPI mode 3 slave transmitter with frame marker.
  Assumes buttons arrive as raw pins (synchronised here) and the
  measurement source offers one word at a time with valid/ready.
*/
// Notes on behaviour
// - Peak-hold button steps min hold, max hold, off, in measurement mode.
// - Range button steps range within the mode's allowed ranges.
// - Comm button in a comm-capable mode enters comm mode.
// - Session ends on word count, comm button, or dial turn.
// - Comm-active indication driven while comm mode is active.
// - One transport, UART or SPI, chosen by build parameter.
// - UART sends at once on entering comm mode.
// - UART 230400 bps, 8 data, 1 stop, no parity, no flow control.
// - SPI slave, mode 3, 8-bit characters, MSB first.
// - SPI master-out line is ignored; data only on slave output.
// - SPI frame marker output tells host transfer start and end.
// - Header, words, end sequence back to back, nothing between.
// - Header: bit7 zero, 6:4 range low bits, 3:0 function.
// - Words sent until count reached or a comm button or dial event.
// - Word size and count per function; continuity cannot communicate.
// - End: 2-byte peak-hold code, 4 fixed bytes, then leave comm mode.
// - Codes FF0D/FF0E/FF0F, fixed pattern 5A 96 96 5A.
// - Dial position gives function code 0..C; others select nothing.
// - Every mode change resets the range to the mode default.
`timescale 1ns/100ps
`include "mrsf_defs.vh"

module mrsf_framer #(
  parameter XPORT = `MRSF_XPORT_UART
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        clk_en,
  input  wire [3:0]  mode_select_dial,
  input  wire        comm_toggle_button,
  input  wire        peak_hold_button,
  input  wire        range_step_button,
  input  wire [31:0] meas_word,
  input  wire        meas_valid,
  output reg         meas_ready,
  input  wire        spi_sck,
  input  wire        spi_mosi,
  output reg         spi_miso,
  output reg         uart_txd,
  output reg         frame_marker_output,
  output reg         comm_active_indication,
  output reg  [3:0]  function_select_field,
  output reg  [2:0]  range_select_field,
  output reg  [1:0]  peak_hold_q,
  output reg         no_function_q
);

  // ============================================================
  // Input synchronisers (three flops, first flop read only by second)
  // ============================================================
  reg [3:0] dial_s1_q, dial_s2_q, dial_s3_q;
  reg [3:0] btn_s1_q, btn_s2_q, btn_s3_q;
  wire [3:0] btn_raw = {spi_sck, range_step_button, peak_hold_button, comm_toggle_button};
  // The MOSI pin is deliberately never sampled: the link is one-way.

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dial_s1_q <= 4'hf;
      dial_s2_q <= 4'hf;
      dial_s3_q <= 4'hf;
      btn_s1_q  <= 4'h8;
      btn_s2_q  <= 4'h8;
      btn_s3_q  <= 4'h8;
    end else if (clk_en) begin
      dial_s1_q <= mode_select_dial;
      dial_s2_q <= dial_s1_q;
      dial_s3_q <= dial_s2_q;
      btn_s1_q  <= btn_raw;
      btn_s2_q  <= btn_s1_q;
      btn_s3_q  <= btn_s2_q;
    end
  end

  wire comm_press  = btn_s2_q[0] & ~btn_s3_q[0];
  wire peak_press  = btn_s2_q[1] & ~btn_s3_q[1];
  wire range_press = btn_s2_q[2] & ~btn_s3_q[2];
  wire sck_fall    = ~btn_s2_q[3] & btn_s3_q[3];
  wire dial_turn   = dial_s2_q != dial_s3_q;

  // ============================================================
  // Per-function decoding
  // ============================================================
  // Highest legal range index for a function
  function [2:0] max_range;
    input [3:0] fn;
    begin
      case (fn)
        `MRSF_FN_DCV, `MRSF_FN_ACV:       max_range = 3'h4;
        `MRSF_FN_DCI, `MRSF_FN_ACI:       max_range = 3'h5;
        `MRSF_FN_OHM_CC:                  max_range = 3'h5;
        `MRSF_FN_OHM_CV:                  max_range = 3'h2;
        `MRSF_FN_CONT, `MRSF_FN_CAP_CV:   max_range = 3'h1;
        `MRSF_FN_CAP_CC:                  max_range = 3'h3;
        default:                          max_range = 3'h0;
      endcase
    end
  endfunction

  // Default range on entry to a function (6 V and 6 mA are index 1)
  function [2:0] def_range;
    input [3:0] fn;
    begin
      case (fn)
        `MRSF_FN_DCV, `MRSF_FN_ACV, `MRSF_FN_DCI, `MRSF_FN_ACI: def_range = 3'h1;
        default:                                                def_range = 3'h0;
      endcase
    end
  endfunction

  // Bytes per word minus one: 1 for 2-byte, 3 for 4-byte words
  function [1:0] word_last;
    input [3:0] fn;
    begin
      case (fn)
        `MRSF_FN_ACV, `MRSF_FN_ACI, `MRSF_FN_CAP_CC, `MRSF_FN_CAP_CV,
        `MRSF_FN_FRQ_V, `MRSF_FN_FRQ_I: word_last = 2'h3;
        default:                        word_last = 2'h1;
      endcase
    end
  endfunction

  // Words per session
  function [9:0] word_count;
    input [3:0] fn;
    begin
      case (fn)
        `MRSF_FN_ACV, `MRSF_FN_ACI:                       word_count = `MRSF_CNT_LONG;
        `MRSF_FN_CAP_CC, `MRSF_FN_CAP_CV,
        `MRSF_FN_FRQ_V, `MRSF_FN_FRQ_I:                   word_count = `MRSF_CNT_FLOAT;
        default:                                          word_count = `MRSF_CNT_SHORT;
      endcase
    end
  endfunction

  wire fn_valid   = dial_s2_q <= `MRSF_FN_TEMP;
  wire comm_capable = ~no_function_q && (function_select_field != `MRSF_FN_CONT);

  // ============================================================
  // Session state machine
  // ============================================================
  localparam [4:0] ST_MEAS = 5'h01;
  localparam [4:0] ST_HDR  = 5'h02;
  localparam [4:0] ST_WORD = 5'h04;
  localparam [4:0] ST_END  = 5'h08;
  localparam [4:0] ST_WAIT = 5'h10;

  reg [4:0]  state_q;
  reg [9:0]  words_q;
  reg [1:0]  byte_q;
  reg [2:0]  end_q;
  reg [31:0] word_q;
  reg        stop_q;
  reg [7:0]  tx_byte;
  reg [7:0]  tx_data_q;
  reg        tx_go;
  wire       tx_idle;

  // Transmit byte selection: header, word byte or end sequence byte
  always @* begin
    case (end_q)
      3'h0:    tx_byte = `MRSF_PH_LEAD;
      3'h1:    tx_byte = (peak_hold_q == `MRSF_PH_MIN) ? `MRSF_PH_CODE_MIN :
                         (peak_hold_q == `MRSF_PH_MAX) ? `MRSF_PH_CODE_MAX : `MRSF_PH_CODE_OFF;
      3'h2:    tx_byte = `MRSF_FIX_0;
      3'h3:    tx_byte = `MRSF_FIX_1;
      3'h4:    tx_byte = `MRSF_FIX_2;
      default: tx_byte = `MRSF_FIX_3;
    endcase
    if (state_q == ST_HDR)
      tx_byte = {1'b0, range_select_field, function_select_field};
    else if (state_q == ST_WORD)
      tx_byte = (byte_q == 2'h3) ? word_q[31:24] : (byte_q == 2'h2) ? word_q[23:16] :
                (byte_q == 2'h1) ? word_q[15:8]  : word_q[7:0];
  end

  // Byte captured with its go strobe: the state moves on in that same edge,
  // so the transmitter must not read tx_byte a cycle later
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      tx_data_q <= 8'hff;
    else if (clk_en && tx_idle && !tx_go &&
             (state_q == ST_HDR || state_q == ST_WORD || state_q == ST_END))
      tx_data_q <= tx_byte;
  end

  // The drain of the last end byte still counts as comm mode for the peak and range buttons
  wire in_comm = (state_q != ST_MEAS) || comm_active_indication;
  wire stop_ev = comm_press | dial_turn;

  // Mode settings: buttons act only outside comm mode; dial acts always
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      function_select_field <= `MRSF_FN_DCV;
      range_select_field    <= 3'h1;
      peak_hold_q           <= `MRSF_PH_OFF;
      no_function_q         <= 1'b0;
    end else if (clk_en) begin
      if (dial_turn) begin
        function_select_field <= dial_s2_q;
        no_function_q         <= ~fn_valid;
        range_select_field    <= def_range(dial_s2_q);
      end else if (!in_comm && peak_press) begin
        peak_hold_q <= (peak_hold_q == `MRSF_PH_OFF) ? `MRSF_PH_MIN : peak_hold_q + 2'h1;
      end else if (!in_comm && range_press) begin
        range_select_field <= (range_select_field >= max_range(function_select_field)) ?
                              3'h0 : range_select_field + 3'h1;
      end
    end
  end

  // Session sequencing: header, words, end bytes back to back
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q                <= ST_MEAS;
      words_q                <= 10'h000;
      byte_q                 <= 2'h0;
      end_q                  <= 3'h0;
      word_q                 <= 32'h0;
      stop_q                 <= 1'b0;
      tx_go                  <= 1'b0;
      meas_ready             <= 1'b0;
      comm_active_indication <= 1'b0;
      frame_marker_output    <= 1'b0;
    end else if (clk_en) begin
      tx_go      <= 1'b0;
      meas_ready <= 1'b0;
      if (in_comm && stop_ev)
        stop_q <= 1'b1;
      case (state_q)
        ST_MEAS: begin
          stop_q <= 1'b0;
          if (comm_press && comm_capable && !dial_turn) begin
            state_q <= ST_HDR;
            comm_active_indication <= 1'b1;
            frame_marker_output    <= (XPORT == `MRSF_XPORT_SPI);
            words_q <= 10'h000;
            end_q   <= 3'h0;
          end
        end
        ST_HDR: if (tx_idle && !tx_go) begin
          tx_go   <= 1'b1;
          state_q <= ST_WAIT;
          byte_q  <= 2'h0;
        end
        ST_WORD: if (tx_idle && !tx_go) begin
          tx_go <= 1'b1;
          if (byte_q == 2'h0) begin
            words_q <= words_q + 10'h001;
            state_q <= ST_WAIT;
          end else
            byte_q <= byte_q - 2'h1;
        end
        ST_END: if (tx_idle && !tx_go) begin
          tx_go <= 1'b1;
          if (end_q == `MRSF_END_LEN - 3'h1)
            state_q <= ST_MEAS;
          else
            end_q <= end_q + 3'h1;
        end
        ST_WAIT: begin
          // Between words: end on count or event, else take next word
          if (stop_q || stop_ev || words_q == word_count(function_select_field))
            state_q <= ST_END;
          else if (meas_valid && tx_idle && !tx_go) begin
            meas_ready <= 1'b1;
            word_q  <= meas_word;
            byte_q  <= word_last(function_select_field);
            state_q <= ST_WORD;
          end
        end
        default: state_q <= ST_MEAS;
      endcase
      // Drop indications only after the last end byte has fully left; on SPI
      // also wait for the clock to rise again, so the host has taken the last bit
      if (state_q == ST_MEAS && !tx_go && tx_idle && comm_active_indication &&
          (XPORT == `MRSF_XPORT_UART || btn_s2_q[3]) &&
          !(comm_press && comm_capable)) begin
        comm_active_indication <= 1'b0;
        frame_marker_output    <= 1'b0;
      end
    end
  end

  // ============================================================
  // Transmitter: UART 8N1 or SPI mode 3 slave, MSB first
  // ============================================================
  reg [9:0] sh_q;
  reg [3:0] bits_q;
  reg [9:0] baud_q;
  assign tx_idle = bits_q == 4'h0;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q     <= 10'h3ff;
      bits_q   <= 4'h0;
      baud_q   <= 10'h000;
      uart_txd <= 1'b1;
      spi_miso <= 1'b1;
    end else if (clk_en) begin
      if (tx_go && tx_idle) begin
        if (XPORT == `MRSF_XPORT_UART) begin
          // Start bit, 8 data LSB first, 1 stop, no parity
          sh_q     <= {1'b1, tx_data_q, 1'b0};
          bits_q   <= `MRSF_DATA_BITS + `MRSF_STOP_BITS + 4'h1;
          baud_q   <= `MRSF_BIT_RELOAD;
          uart_txd <= 1'b0;
        end else begin
          // Line left alone on load: bit 0 of the last byte may not be taken yet.
          // The first falling edge then drives the MSB
          sh_q     <= {tx_data_q, 2'h3};
          bits_q   <= `MRSF_DATA_BITS;
        end
      end else if (!tx_idle) begin
        if (XPORT == `MRSF_XPORT_UART) begin
          if (baud_q == 10'h000) begin
            baud_q   <= `MRSF_BIT_RELOAD;
            bits_q   <= bits_q - 4'h1;
            uart_txd <= sh_q[1];
            sh_q     <= {1'b1, sh_q[9:1]};
          end else
            baud_q <= baud_q - 10'h001;
        end else if (sck_fall) begin
          // Mode 3: shift on falling edge, host samples on rising
          bits_q   <= bits_q - 4'h1;
          spi_miso <= sh_q[9];
          sh_q     <= {sh_q[8:0], 1'b1};
        end
      end
    end
  end

endmodule // mrsf_framer

// [rtl/mrsf_defs.vh]
/*
  Constants for the meter result serial framer: header layout, end
  sequence, word formats and counts, link timing.
  Assumes inclusion by bare name from the framer module only.
*/
`ifndef MRSF_DEFS_VH
`define MRSF_DEFS_VH

// ============================================================
// Clock and link timing
// ============================================================
`define MRSF_CLK_HZ        100000000
`define MRSF_BAUD_BPS      230400
`define MRSF_BIT_CYC       (`MRSF_CLK_HZ / `MRSF_BAUD_BPS)
`define MRSF_BIT_CYC_W     10
`define MRSF_BIT_RELOAD    10'h1b1   // Bit time minus one, 434 cycles
`define MRSF_DATA_BITS     4'h8
`define MRSF_STOP_BITS     4'h1

// ============================================================
// Transport selection
// ============================================================
`define MRSF_XPORT_UART    1'b0
`define MRSF_XPORT_SPI     1'b1

// ============================================================
// Function codes (dial positions)
// ============================================================
`define MRSF_FN_DCV        4'h0
`define MRSF_FN_ACV        4'h1
`define MRSF_FN_DCI        4'h2
`define MRSF_FN_ACI        4'h3
`define MRSF_FN_OHM_CC     4'h4
`define MRSF_FN_OHM_CV     4'h5
`define MRSF_FN_CONT       4'h6
`define MRSF_FN_CAP_CC     4'h7
`define MRSF_FN_CAP_CV     4'h8
`define MRSF_FN_DIODE      4'h9
`define MRSF_FN_FRQ_V      4'ha
`define MRSF_FN_FRQ_I      4'hb
`define MRSF_FN_TEMP       4'hc

// ============================================================
// Session words and end sequence
// ============================================================
`define MRSF_CNT_SHORT     10'h1f4
`define MRSF_CNT_LONG      10'h0fa
`define MRSF_CNT_FLOAT     10'h064
`define MRSF_PH_MIN        2'h0
`define MRSF_PH_MAX        2'h1
`define MRSF_PH_OFF        2'h2
`define MRSF_PH_LEAD       8'hff
`define MRSF_PH_CODE_MIN   8'h0d
`define MRSF_PH_CODE_MAX   8'h0e
`define MRSF_PH_CODE_OFF   8'h0f
`define MRSF_FIX_0         8'h5a
`define MRSF_FIX_1         8'h96
`define MRSF_FIX_2         8'h96
`define MRSF_FIX_3         8'h5a
`define MRSF_END_LEN       3'h6
`define MRSF_HDR_MSB       7
`define MRSF_RANGE_MSB     6
`define MRSF_RANGE_LSB     4

`endif

// [verification/mrsf_framer_asserts.sv]
/*
  Checker for the meter result serial framer: settings, session and link rules.
  Assumes it is bound to mrsf_framer and sees only that module's ports.
*/
`timescale 1ns/100ps
// ============================================================
// Checker module
// ============================================================
module mrsf_framer_asserts #(
  parameter XPORT = 1'b0
) (
  input wire       sys_clk,
  input wire       rst,
  input wire       meas_ready,
  input wire       uart_txd,
  input wire       frame_marker_output,
  input wire       comm_active_indication,
  input wire [3:0] function_select_field,
  input wire [2:0] range_select_field,
  input wire [1:0] peak_hold_q,
  input wire       no_function_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // UART line must stay idle when the SPI transport is built
  a_uart_idle_spi: assert property ((XPORT == 1) |-> uart_txd)
    else $error("uart line active in spi build");
  // Marker comes up together with the session
  a_marker_at_start: assert property ((XPORT == 1) && $rose(comm_active_indication)
    |-> ##[0:1] frame_marker_output) else $error("frame marker late at session start");
  // Peak setting walks min, max, off and wraps
  a_peak_step: assert property ($changed(peak_hold_q)
    |-> peak_hold_q == (($past(peak_hold_q) == 2'h2) ? 2'h0 : $past(peak_hold_q) + 2'h1))
    else $error("peak hold stepped out of order");
  // Peak presses have no effect while a session runs
  a_peak_frozen: assert property (comm_active_indication && $past(comm_active_indication)
    |-> $stable(peak_hold_q)) else $error("peak hold changed in session");
  // Range only moves with the function while a session runs
  a_range_frozen: assert property (comm_active_indication && $past(comm_active_indication)
    && $stable(function_select_field) |-> $stable(range_select_field))
    else $error("range changed in session");
  // A new function of code 0..9 always starts from its default range
  a_range_default: assert property ($changed(function_select_field)
    && function_select_field <= 4'h9
    |-> range_select_field == ((function_select_field < 4'h4) ? 3'h1 : 3'h0))
    else $error("range not reset to default on mode change");
  // No session may start in continuity or with no function
  a_no_comm_cont: assert property ($rose(comm_active_indication)
    |-> function_select_field != 4'h6 && !no_function_q)
    else $error("session started in unsupported mode");
  // Words are only taken inside a session, one cycle at a time
  a_ready_in_comm: assert property (meas_ready |-> comm_active_indication
    ##1 !meas_ready) else $error("word taken outside session");
endmodule // mrsf_framer_asserts

bind mrsf_framer mrsf_framer_asserts #(.XPORT(XPORT)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .meas_ready(meas_ready), .uart_txd(uart_txd),
  .frame_marker_output(frame_marker_output), .comm_active_indication(comm_active_indication),
  .function_select_field(function_select_field), .range_select_field(range_select_field),
  .peak_hold_q(peak_hold_q), .no_function_q(no_function_q));

// [verification/mrsf_host_model.sv]
/*
  Host side of the one-way SPI link: mode 3 master clocking bytes while
  the frame marker is high. Assumes the framer moves a bit on each falling edge.
*/
`timescale 1ns/100ps
// ============================================================
// SPI master model
// ============================================================
module mrsf_host_model (
  input wire frame_marker_output,
  input wire spi_miso,
  output reg spi_sck,
  output reg spi_mosi
);
  reg [7:0] rx [0:1023];
  reg [7:0] b;
  integer   rx_cnt;
  integer   i;

  // Clock stands high outside frames; bytes spaced so the slave can reload
  initial begin
    spi_sck  = 1'b1;
    spi_mosi = 1'b0;
    rx_cnt   = 0;
    b        = 8'h00;
    forever begin
      @(posedge frame_marker_output);
      #2000;
      while (frame_marker_output === 1'b1) begin
        for (i = 0; i < 8; i = i + 1) begin
          #62.5 spi_sck = 1'b0;
          spi_mosi = ~spi_mosi; // Junk on the unused line
          #62.5 spi_sck = 1'b1;
          b = {b[6:0], spi_miso}; // MSB first on rising edge
        end
        rx[rx_cnt] = b;
        rx_cnt = rx_cnt + 1;
        #1000;
      end
    end
  end
endmodule // mrsf_host_model

// [verification/test_mrsf_framer.sv]
/*
  Self-checking bench for the framer in its SPI build: settings, refusals
  and three sessions ended by button or dial; a UART build alongside sends
  its first header unasked. Assumes the host model.
*/
`timescale 1ns/100ps
// ============================================================
// Bench top
// ============================================================
module test_mrsf_framer;
  reg         sys_clk = 1'b0;
  reg         rst     = 1'b1;
  reg  [3:0]  dial    = 4'h0;
  reg         comm_b  = 1'b0;
  reg         peak_b  = 1'b0;
  reg         range_b = 1'b0;
  reg  [31:0] word    = 32'h1234abcd;
  reg  [7:0]  hdr;
  reg  [7:0]  code;
  wire        ready, sck, mosi, miso, txd, marker, ind, nofn;
  wire [3:0]  fn;
  wire [2:0]  rng;
  wire [1:0]  peak;
  wire        txd_u;
  reg  [7:0]  u_b, u_hdr;
  integer     u_cnt = 0;
  integer     u_i;
  integer     miscompares = 0;
  integer     num_checks  = 0;
  integer     k, s, n, len, w;

  always #5 sys_clk = ~sys_clk;

  mrsf_framer #(.XPORT(1'b1)) uut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .mode_select_dial(dial),
    .comm_toggle_button(comm_b), .peak_hold_button(peak_b), .range_step_button(range_b),
    .meas_word(word), .meas_valid(1'b1), .meas_ready(ready), .spi_sck(sck),
    .spi_mosi(mosi), .spi_miso(miso), .uart_txd(txd), .frame_marker_output(marker),
    .comm_active_indication(ind), .function_select_field(fn), .range_select_field(rng),
    .peak_hold_q(peak), .no_function_q(nofn));

  mrsf_host_model host (
    .frame_marker_output(marker), .spi_miso(miso), .spi_sck(sck), .spi_mosi(mosi));

  // UART build fed the same buttons; its first byte and every stop bit are judged
  mrsf_framer #(.XPORT(1'b0)) uut_uart (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .mode_select_dial(dial),
    .comm_toggle_button(comm_b), .peak_hold_button(peak_b), .range_step_button(range_b),
    .meas_word(word), .meas_valid(1'b1), .meas_ready(), .spi_sck(1'b1),
    .spi_mosi(1'b0), .spi_miso(), .uart_txd(txd_u), .frame_marker_output(),
    .comm_active_indication(), .function_select_field(), .range_select_field(),
    .peak_hold_q(), .no_function_q());

  // UART receiver: 4340 ns bits sampled mid-bit, LSB first, stop bit high
  initial begin
    forever begin
      @(negedge txd_u);
      #6510;
      for (u_i = 0; u_i < 8; u_i = u_i + 1) begin
        u_b = {txd_u, u_b[7:1]};
        #4340;
      end
      chk(txd_u, 1'b1);
      if (u_cnt == 0) u_hdr = u_b;
      u_cnt = u_cnt + 1;
    end
  end

  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task tick(input integer c);
    repeat (c) @(negedge sys_clk);
  endtask

  // Press held long enough for the synchroniser: 0 comm, 1 peak, 2 range
  task press(input integer which);
    begin
      tick(1);
      case (which)
        0: comm_b = 1'b1;
        1: peak_b = 1'b1;
        default: range_b = 1'b1;
      endcase
      tick(6);
      comm_b = 1'b0;
      peak_b = 1'b0;
      range_b = 1'b0;
      tick(6);
    end
  endtask

  task print_verdict;
    begin
      if (miscompares == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // Bounded wait for the host to hold at least c bytes
  task wait_rx(input integer c);
    begin
      for (w = 0; w < 20000 && host.rx_cnt < c; w = w + 1) tick(1);
      if (w == 20000) begin miscompares = miscompares + 1; print_verdict; end
    end
  endtask

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    tick(4);
    rst = 1'b0;
    tick(10);
    chk(ind, 1'b0); chk(marker, 1'b0); chk(miso, 1'b1);
    chk(txd, 1'b1); chk(peak, 2'h2); chk(fn, 4'h0); chk(rng, 3'h1);
    for (k = 0; k < 3; k = k + 1) begin
      press(1);
      chk(peak, k);
    end
    press(2);
    chk(rng, 3'h2);
    dial = 4'h1;
    tick(8);
    chk(fn, 4'h1); chk(rng, 3'h1);
    dial = 4'h6;
    tick(8);
    press(0);
    chk(ind, 1'b0);
    dial = 4'hd;
    tick(8);
    chk(nofn, 1'b1);
    press(0);
    chk(ind, 1'b0);
    // Three sessions, one per peak code; the second is cut by the dial
    for (s = 0; s < 3; s = s + 1) begin
      case (s)
        0: begin dial = 4'h0; len = 2; hdr = 8'h10; code = 8'h0d; end
        1: begin dial = 4'h1; len = 4; hdr = 8'h11; code = 8'h0e; end
        default: begin dial = 4'h7; len = 4; hdr = 8'h07; code = 8'h0f; end
      endcase
      tick(8);
      press(1);
      host.rx_cnt = 0;
      press(0);
      chk(ind, 1'b1); chk(marker, 1'b1);
      wait_rx(4);
      press(1);
      chk(peak, s);
      if (s == 1) dial = 4'h2;
      else press(0);
      for (w = 0; w < 20000 && marker !== 1'b0; w = w + 1) tick(1);
      if (w == 20000) begin miscompares = miscompares + 1; print_verdict; end
      tick(5);
      chk(ind, 1'b0);
      n = host.rx_cnt;
      chk(host.rx[0], hdr);
      // The stop lands in the word in flight: two 2-byte words or one 4-byte word
      chk((n - 7) % len, 0); chk(n, 11);
      for (k = 1; k < n - 6; k = k + 1)
        chk(host.rx[k], (word >> (8 * (len - 1 - (k - 1) % len))) & 32'hff);
      chk(host.rx[n-6], 8'hff); chk(host.rx[n-5], code);
      chk({host.rx[n-4], host.rx[n-3], host.rx[n-2], host.rx[n-1]}, 32'h5a96965a);
    end
    // The UART build sent its header at session entry with no host request
    for (w = 0; w < 20000 && u_cnt < 1; w = w + 1) tick(1);
    if (w == 20000) miscompares = miscompares + 1;
    chk(u_hdr, 8'h10);
    print_verdict;
  end
endmodule // test_mrsf_framer
